/* design/lcr_map.vh */
// constants for the light curtain reset and indicator block
`ifndef LCR_MAP_VH
`define LCR_MAP_VH
`define LCR_CLK_HZ        125000000
`define LCR_RST_MIN_MS    250
`define LCR_RST_MAX_MS    2000
`define LCR_DEB_US        1000
`define LCR_BLINK_MS      250
`define LCR_PUP_MS        1500
`define LCR_SCAN_MS       1500
// byte addresses on the ahb-lite slave
`define LCR_A_CTRL        12'h000
`define LCR_A_BEAMS       12'h004
`define LCR_A_CODES       12'h008
`define LCR_A_STATUS      12'h00c
`define LCR_A_LAMPS       12'h010
`define LCR_A_DISP        12'h014
`define LCR_A_EMIT        12'h018
// ctrl fields
`define LCR_C_LATCH       0
`define LCR_C_RR          1
`define LCR_C_FAULT       2
`define LCR_C_EFAULT      3
`define LCR_C_TEST        4
`define LCR_C_NOISE_R     5
`define LCR_C_NOISE_M     6
`define LCR_C_SCAN        7
`define LCR_C_PUP_DONE    8
`define LCR_CTRL_RST      32'h00000000
// display glyph codes (4 bits each)
`define LCR_G_BLANK       4'h0
`define LCR_G_DASH        4'ha
`define LCR_G_L           4'hb
`define LCR_G_E           4'hc
`define LCR_G_S           4'hd
// lamp colour codes
`define LCR_LAMP_OFF      2'h0
`define LCR_LAMP_GREEN    2'h1
`define LCR_LAMP_RED      2'h2
`endif

/* design/lcr_sync.v */
// two-flop synchroniser and debouncer for the reset contact
module lcr_sync #(
  parameter DEB_CYC = 125000
) (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire pin,
  output reg  level
);
  reg        s1;
  reg        s2;
  reg [16:0] cnt;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      cnt   <= 17'h00000;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      if (s2 == level)
        cnt <= 17'h00000;
      else if (cnt == DEB_CYC[16:0] - 17'h00001) begin
        cnt   <= 17'h00000;
        level <= s2;
      end else
        cnt <= cnt + 17'h00001;
    end
  end
endmodule

/* design/lcr_top.v */
// reset qualification, run/latch state and indicator drive of the receiver
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`include "lcr_map.vh"
module lcr_top #(
  parameter RST_MIN_CYC = (`LCR_CLK_HZ / 1000) * `LCR_RST_MIN_MS,
  parameter RST_MAX_CYC = (`LCR_CLK_HZ / 1000) * `LCR_RST_MAX_MS,
  parameter BLINK_CYC   = (`LCR_CLK_HZ / 1000) * `LCR_BLINK_MS,
  parameter PUP_CYC     = (`LCR_CLK_HZ / 1000) * `LCR_PUP_MS,
  parameter DEB_CYC     = (`LCR_CLK_HZ / 1000000) * `LCR_DEB_US
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        reset_contact,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hsel,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [1:0]  safety_output_pair,
  output reg         reset_lamp,
  output reg  [1:0]  status_lamp,
  output reg  [15:0] zone_lamps,
  output reg  [11:0] disp_digits,
  output reg  [2:0]  disp_blank,
  output reg  [1:0]  emit_lamp,
  output reg  [3:0]  emit_digit
);
  localparam ST_PUP  = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_RUN  = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_LOCK = 3'h4;

  // software-written registers
  reg [31:0] ctrl;
  reg [31:0] beams;     // [7:0] blocked per zone, [15:8] blanked, [23:16] blocked count
  reg [31:0] codes;     // [7:0] rx error code, [11:8] emitter error code
  reg [31:0] emit;      // [0] emitter lockout
  // ahb data phase
  reg        dp_valid;
  reg        dp_write;
  reg [11:0] dp_addr;
  // reset qualification
  wire       contact;
  reg        was_open;
  reg        closed_prev;
  reg [28:0] hold_cnt;
  reg        too_long;
  reg        reset_pulse;
  reg        reset_seen;
  // state
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [27:0] pup_cnt;
  reg        pup_active;
  reg [27:0] blink_cnt;
  reg        blink;
  reg        scan_prev;
  reg [27:0] scan_cnt;
  reg        emit_pup;
  reg [27:0] emit_cnt;

  lcr_sync #(.DEB_CYC(DEB_CYC)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (reset_contact),
    .level   (contact)
  );

  function [1:0] flash;
    input [1:0] col;
    input       on;
    begin
      flash = on ? col : `LCR_LAMP_OFF;
    end
  endfunction

  wire latch_mode = ctrl[`LCR_C_LATCH];
  wire any_fault  = ctrl[`LCR_C_FAULT] | ctrl[`LCR_C_EFAULT];
  wire all_clear  = (beams[7:0] == 8'h00);

  // a read right behind a write to the same word returns the new value
  wire        wr_now   = dp_valid && dp_write;
  wire [31:0] ctrl_rd  = (wr_now && dp_addr == `LCR_A_CTRL)  ? hwdata : ctrl;
  wire [31:0] beams_rd = (wr_now && dp_addr == `LCR_A_BEAMS) ? hwdata : beams;
  wire [31:0] codes_rd = (wr_now && dp_addr == `LCR_A_CODES) ? hwdata : codes;
  wire        emit_rd  = (wr_now && dp_addr == `LCR_A_EMIT)  ? hwdata[0] : emit[0];

  // ahb-lite slave, zero wait states
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      ctrl      <= `LCR_CTRL_RST;
      beams     <= 32'h00000000;
      codes     <= 32'h00000000;
      emit      <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (dp_valid && dp_write) begin
        case (dp_addr)
          `LCR_A_CTRL:  ctrl  <= hwdata;
          `LCR_A_BEAMS: beams <= hwdata;
          `LCR_A_CODES: codes <= hwdata;
          `LCR_A_EMIT:  emit  <= hwdata;
          default: ;
        endcase
      end
      if (hready) begin
        dp_valid <= hsel & htrans[1];
        dp_write <= hwrite;
        dp_addr  <= {haddr[11:2], 2'b00};
        if (hsel && htrans[1] && !hwrite) begin
          case ({haddr[11:2], 2'b00})
            `LCR_A_CTRL:   hrdata <= ctrl_rd;
            `LCR_A_BEAMS:  hrdata <= beams_rd;
            `LCR_A_CODES:  hrdata <= codes_rd;
            `LCR_A_STATUS: hrdata <= {24'h000000, reset_seen, pup_active,
                                      state, safety_output_pair, contact};
            `LCR_A_LAMPS:  hrdata <= {zone_lamps, 10'h000, status_lamp,
                                      reset_lamp, 3'h0};
            `LCR_A_DISP:   hrdata <= {17'h00000, disp_blank, disp_digits};
            `LCR_A_EMIT:   hrdata <= {26'h0000000, emit_lamp, emit_digit[3:1],
                                      emit_rd};
            default:       hrdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // reset contact timing: open-closed-open, 1/4 to 2 s
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      was_open    <= 1'b0;
      closed_prev <= 1'b0;
      hold_cnt    <= 29'h00000000;
      too_long    <= 1'b0;
      reset_pulse <= 1'b0;
      reset_seen  <= 1'b0;
    end else begin
      closed_prev <= contact;
      reset_pulse <= 1'b0;
      // the debounced level reads open just after reset even with the contact held
      if (!contact && !pup_active)
        was_open <= 1'b1;
      if (contact && !closed_prev) begin
        hold_cnt <= 29'h00000000;
        too_long <= 1'b0;
      end else if (contact) begin
        if (hold_cnt == RST_MAX_CYC[28:0])
          too_long <= 1'b1;
        else
          hold_cnt <= hold_cnt + 29'h00000001;
      end
      if (!contact && closed_prev) begin
        if (was_open && !too_long && hold_cnt >= RST_MIN_CYC[28:0]) begin
          reset_pulse <= 1'b1;
          reset_seen  <= 1'b1;
        end
      end
    end
  end

  // power-up window, blink enable, scan code display timer
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pup_cnt    <= 28'h0000000;
      pup_active <= 1'b1;
      blink_cnt  <= 28'h0000000;
      blink      <= 1'b0;
      scan_prev  <= 1'b0;
      scan_cnt   <= 28'h0000000;
      emit_pup   <= 1'b1;
      emit_cnt   <= 28'h0000000;
    end else begin
      if (blink_cnt == BLINK_CYC[27:0] - 28'h0000001) begin
        blink_cnt <= 28'h0000000;
        blink     <= ~blink;
      end else
        blink_cnt <= blink_cnt + 28'h0000001;
      if (pup_active) begin
        if (pup_cnt == PUP_CYC[27:0] - 28'h0000001)
          pup_active <= 1'b0;
        else
          pup_cnt <= pup_cnt + 28'h0000001;
      end
      scan_prev <= ctrl[`LCR_C_SCAN];
      if (ctrl[`LCR_C_SCAN] != scan_prev)
        scan_cnt <= PUP_CYC[27:0];
      else if (scan_cnt != 28'h0000000)
        scan_cnt <= scan_cnt - 28'h0000001;
      if (emit_pup) begin
        if (emit_cnt == PUP_CYC[27:0] - 28'h0000001)
          emit_pup <= 1'b0;
        else
          emit_cnt <= emit_cnt + 28'h0000001;
      end
    end
  end

  // run / wait / stop / lockout
  always @* begin
    next_state = state;
    case (state)
      ST_PUP:
        if (!pup_active)
          next_state = any_fault ? ST_LOCK : (latch_mode ? ST_WAIT : ST_RUN);
      ST_WAIT:
        if (any_fault)
          next_state = ST_LOCK;
        else if (reset_pulse && all_clear)
          next_state = ST_RUN;
      ST_RUN:
        if (any_fault)
          next_state = ST_LOCK;
        else if (!all_clear)
          next_state = ST_STOP;
      ST_STOP:
        if (any_fault)
          next_state = ST_LOCK;
        else if (all_clear && !latch_mode)
          next_state = ST_RUN;
        else if (all_clear && reset_pulse)
          next_state = ST_RUN;
      ST_LOCK:
        if (!any_fault && reset_pulse)
          next_state = ST_RUN;
      default:
        next_state = ST_LOCK;
    endcase
  end

  wire in_lock  = (state == ST_LOCK);
  wire in_run   = (state == ST_RUN);
  wire waiting  = (state == ST_WAIT) || (state == ST_STOP && latch_mode) || in_lock;
  wire show_scan = pup_active || (scan_cnt != 28'h0000000);
  wire [3:0] scan_glyph = ctrl[`LCR_C_SCAN] ? 4'h2 : 4'h1;

  integer z;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state              <= ST_PUP;
      safety_output_pair <= 2'b00;
      reset_lamp         <= 1'b0;
      status_lamp        <= `LCR_LAMP_OFF;
      zone_lamps         <= 16'h0000;
      disp_digits        <= 12'h000;
      disp_blank         <= 3'h7;
      emit_lamp          <= `LCR_LAMP_OFF;
      emit_digit         <= `LCR_G_BLANK;
    end else begin
      state              <= next_state;
      safety_output_pair <= (in_run && all_clear && !any_fault) ? 2'b11 : 2'b00;
      // yellow lamp: steady in run, flashing while a reset is awaited in wait or latched stop, dark at power-up and in lockout
      if (state == ST_PUP || in_lock)
        reset_lamp <= 1'b0;
      else if (waiting)
        reset_lamp <= blink;
      else
        reset_lamp <= 1'b1;
      if (state == ST_PUP)
        status_lamp <= `LCR_LAMP_RED;
      else if (in_lock)
        status_lamp <= flash(`LCR_LAMP_RED, blink);
      else if (in_run && all_clear)
        status_lamp <= ctrl[`LCR_C_RR] ? flash(`LCR_LAMP_GREEN, blink)
                                       : `LCR_LAMP_GREEN;
      else
        status_lamp <= `LCR_LAMP_RED;
      for (z = 0; z < 8; z = z + 1) begin
        if (state == ST_PUP)
          zone_lamps[2*z +: 2] <= `LCR_LAMP_RED;
        else if (in_lock)
          zone_lamps[2*z +: 2] <= `LCR_LAMP_OFF;
        else if (z != 0 && beams[0])
          zone_lamps[2*z +: 2] <= `LCR_LAMP_OFF;
        else if (beams[z])
          zone_lamps[2*z +: 2] <= `LCR_LAMP_RED;
        else if (beams[8+z])
          zone_lamps[2*z +: 2] <= flash(`LCR_LAMP_GREEN, blink);
        else
          zone_lamps[2*z +: 2] <= `LCR_LAMP_GREEN;
      end
      // diagnostic display
      if (in_lock) begin
        disp_digits <= {4'h0, codes[7:0]};
        disp_blank  <= 3'h0;
      end else if (show_scan) begin
        disp_digits <= {`LCR_G_S, `LCR_G_BLANK, scan_glyph};
        disp_blank  <= {3{~blink}};
      end else if (!all_clear) begin
        disp_digits <= {4'h0, beams[23:16]};
        disp_blank  <= 3'h0;
      end else begin
        disp_digits <= {`LCR_G_BLANK, latch_mode ? `LCR_G_L : `LCR_G_DASH,
                        `LCR_G_BLANK};
        disp_blank  <= {ctrl[`LCR_C_NOISE_R] & blink, 1'b0,
                        ctrl[`LCR_C_NOISE_M] & blink};
      end
      // emitter indicators
      if (emit_pup) begin
        emit_lamp  <= `LCR_LAMP_RED;
        emit_digit <= scan_glyph;
      end else if (emit[0]) begin
        emit_lamp  <= flash(`LCR_LAMP_RED, blink);
        emit_digit <= codes[11:8];
      end else begin
        emit_lamp  <= ctrl[`LCR_C_TEST] ? flash(`LCR_LAMP_GREEN, blink) : `LCR_LAMP_GREEN;
        emit_digit <= (scan_cnt != 28'h0000000) ? scan_glyph : `LCR_G_BLANK;
      end
    end
  end
endmodule

/* testbench/lcr_top_asserts.sv */
// concurrent checks on the ports of the reset and indicator block
`include "lcr_map.vh"
module lcr_chk #(
  parameter RST_MIN_CYC = 40,
  parameter RST_MAX_CYC = 200,
  parameter DEB_CYC     = 2
) (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        reset_contact,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hsel,
  input wire [31:0] hwdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [1:0]  safety_output_pair,
  input wire        reset_lamp,
  input wire [1:0]  status_lamp,
  input wire [15:0] zone_lamps
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        wp, lm, flt, b1;
  logic [11:0] wa;
  logic [15:0] cl, ll, so;
  // shadow of written mode bits, closure length and time since reopening
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp <= 1'b0;
      lm <= 1'b0;
      flt <= 1'b0;
      b1 <= 1'b0;
      so <= 16'hffff;
    end else begin
      wp <= hsel && htrans[1] && hwrite;
      if (wp && wa == `LCR_A_CTRL) begin
        lm <= hwdata[`LCR_C_LATCH];
        flt <= |hwdata[`LCR_C_EFAULT:`LCR_C_FAULT];
      end
      if (wp && wa == `LCR_A_BEAMS)
        b1 <= hwdata[0];
      if (reset_contact)
        so <= 16'h0;
      else if (so != 16'hffff)
        so <= so + 16'h1;
    end
    wa <= haddr[11:0];
    cl <= reset_contact ? cl + 16'h1 : 16'h0;
    if (!reset_contact && cl != 16'h0)
      ll <= cl;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  bus_okay_a: assert property (hsel && htrans[1] |-> hreadyout && !hresp ##1 hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  pair_equal_a: assert property (safety_output_pair[0] == safety_output_pair[1])
    else $error("safety output channels differ");
  status_colour_a: assert property ($stable(safety_output_pair)[*3] |->
    status_lamp != (safety_output_pair[0] ? `LCR_LAMP_RED : `LCR_LAMP_GREEN))
    else $error("status lamp colour disagrees with outputs");
  run_lamp_a: assert property ((safety_output_pair == 2'b11)[*3] |-> reset_lamp)
    else $error("reset lamp dark in run");
  pup_quiet_a: assert property ($rose(rst_n) |->
    (safety_output_pair == 2'b00 && !reset_lamp)[*8])
    else $error("outputs or reset lamp on at power-up");
  zone_sync_a: assert property (b1 && $past(b1, 4) |-> zone_lamps[15:2] == 14'h0)
    else $error("upper zone lamps lit while beam one blocked");
  lock_dark_a: assert property ($rose(flt) |-> ##6
    (safety_output_pair == 2'b00 && !reset_lamp && zone_lamps == 16'h0))
    else $error("lockout indication wrong");
  reset_window_a: assert property (lm && $rose(safety_output_pair[0]) |->
    so < 16'd40 && ll + DEB_CYC + 4 >= RST_MIN_CYC && ll <= RST_MAX_CYC + DEB_CYC + 4)
    else $error("latch outputs on without a valid reset");
  cover property ($rose(safety_output_pair[0]));
  cover property (lm && $rose(safety_output_pair[0]));
  cover property ($rose(flt));
endmodule
bind lcr_top lcr_chk #(
  .RST_MIN_CYC(RST_MIN_CYC),
  .RST_MAX_CYC(RST_MAX_CYC),
  .DEB_CYC(DEB_CYC)
) u_chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .reset_contact(reset_contact),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsel(hsel),
  .hwdata(hwdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .safety_output_pair(safety_output_pair),
  .reset_lamp(reset_lamp),
  .status_lamp(status_lamp),
  .zone_lamps(zone_lamps)
);

/* testbench/lcr_switch.sv */
// operator reset switch and machine control model
module lcr_switch (
  input  wire logic       ref_clk,
  input  wire logic [1:0] safety_output_pair,
  output logic            reset_contact,
  output logic            machine_run
);
  timeunit 1ns;
  timeprecision 1ps;
  // machine may move only while both channels are on
  assign machine_run = &safety_output_pair;
  initial reset_contact = 1'b0;
  // normally open contact: open, closed for n cycles, open again
  task automatic press(input int n);
    @(posedge ref_clk);
    reset_contact <= 1'b1;
    repeat (n) @(posedge ref_clk);
    reset_contact <= 1'b0;
  endtask
  task automatic hold(input logic c);
    @(posedge ref_clk);
    reset_contact <= c;
  endtask
endmodule

/* testbench/tb_lcr_top.sv */
// self-checking bench for the reset and indicator block
`include "lcr_map.vh"
module tb_lcr_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MINC = 40;
  localparam int MAXC = 200;
  localparam int BLK  = 4;
  localparam int GOOD = (MINC + MAXC) / 2;
  localparam int PUP  = 50;
  localparam int DEB  = 2;
  logic        ref_clk, rst_n, hwrite, hsel;
  logic [31:0] haddr, hwdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] s;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, reset_lamp, reset_contact, machine_run;
  wire  [1:0]  safety_output_pair, status_lamp, emit_lamp;
  wire  [15:0] zone_lamps;
  wire  [11:0] disp_digits;
  wire  [2:0]  disp_blank;
  wire  [3:0]  emit_digit;
  int          errors, checks, cyc;
  lcr_top #(
    .RST_MIN_CYC(MINC),
    .RST_MAX_CYC(MAXC),
    .BLINK_CYC(BLK),
    .PUP_CYC(PUP),
    .DEB_CYC(DEB)
  ) dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reset_contact(reset_contact),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hsel(hsel),
    .hready(hreadyout),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .safety_output_pair(safety_output_pair),
    .reset_lamp(reset_lamp),
    .status_lamp(status_lamp),
    .zone_lamps(zone_lamps),
    .disp_digits(disp_digits),
    .disp_blank(disp_blank),
    .emit_lamp(emit_lamp),
    .emit_digit(emit_digit)
  );
  lcr_switch sw (
    .ref_clk(ref_clk),
    .safety_output_pair(safety_output_pair),
    .reset_contact(reset_contact),
    .machine_run(machine_run)
  );
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc = 0;
    forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 20000) begin
        errors++;
        end_of_test();
      end
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic sel);
    @(posedge ref_clk);
    haddr <= {20'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    hsel <= sel;
    htrans <= 2'b10;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wsop(input logic [1:0] e);
    int n;
    for (n = 0; n < 400 && safety_output_pair !== e; n++) @(posedge ref_clk);
    chk(safety_output_pair, e);
  endtask
  // collects which levels the flashing indicators took
  task automatic blink;
    s = 12'h000;
    repeat (8 * BLK) begin
      @(posedge ref_clk);
      s = s | {reset_lamp, !reset_lamp, disp_blank[2], !disp_blank[2],
               disp_blank[0], !disp_blank[0],
               status_lamp == `LCR_LAMP_GREEN, status_lamp == `LCR_LAMP_OFF,
               emit_lamp == `LCR_LAMP_GREEN, emit_lamp == `LCR_LAMP_OFF,
               zone_lamps[15:14] == `LCR_LAMP_GREEN, zone_lamps[15:14] == `LCR_LAMP_OFF};
    end
  endtask
  initial begin
    rst_n = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsel = 1'b0;
    hsize = 3'h0;
    errors = 0;
    checks = 0;
    repeat (20) @(posedge ref_clk);
    chk({hreadyout, hresp, disp_blank, safety_output_pair}, 7'h5c);
    rst_n <= 1'b1;
    rd(`LCR_A_CTRL);
    chk(q, `LCR_CTRL_RST);
    rd(12'h01c);
    chk(q, 32'h0);
    rd(`LCR_A_STATUS);
    chk({reset_lamp, q[6:1]}, 7'h20);
    chk({disp_digits, emit_digit}, 16'hd011);
    chk({status_lamp, zone_lamps}, 18'h2aaaa);
    wsop(2'b11);
    idle(4);
    chk({machine_run, reset_lamp, status_lamp, emit_lamp, zone_lamps}, 22'h355555);
    wr(`LCR_A_BEAMS, 32'h0005_0004);
    wsop(2'b00);
    idle(4);
    chk({status_lamp, zone_lamps[5:4], disp_digits[3:0]}, 8'ha5);
    wr(`LCR_A_BEAMS, 32'h0);
    wsop(2'b11);
    wr(`LCR_A_BEAMS, 32'h0001_0001);
    wsop(2'b00);
    idle(4);
    chk(zone_lamps, 16'h0002);
    wr(`LCR_A_BEAMS, 32'h0);
    wsop(2'b11);
    wr(`LCR_A_CODES, 32'h0000_0937);
    bus(1'b1, `LCR_A_CODES, 32'hffff_ffff, 1'b0);
    rd(`LCR_A_CODES);
    chk(q, 32'h0000_0937);
    wr(`LCR_A_CTRL, 32'h4);
    wsop(2'b00);
    idle(4);
    rd(`LCR_A_STATUS);
    chk({reset_lamp, zone_lamps, q[5:3]}, 20'h4);
    rd(`LCR_A_DISP);
    chk(q, 32'h0000_0037);
    wr(`LCR_A_CTRL, 32'h0);
    idle(30);
    chk(safety_output_pair, 2'b00);
    sw.press(GOOD);
    wsop(2'b11);
    wr(`LCR_A_BEAMS, 32'h0000_8000);
    wr(`LCR_A_CTRL, 32'hd2);
    idle(4);
    chk({disp_digits, emit_digit}, 16'hd022);
    idle(60);
    chk(disp_digits, 12'h0a0);
    blink;
    chk(s[9:0], 10'h1ff);
    wr(`LCR_A_CTRL, 32'h1);
    wr(`LCR_A_BEAMS, 32'h0001_0002);
    wsop(2'b00);
    wr(`LCR_A_BEAMS, 32'h0);
    wr(`LCR_A_CTRL, 32'h21);
    blink;
    chk(s[11:8], 4'hf);
    wr(`LCR_A_CTRL, 32'h1);
    sw.press(MINC / 2);
    idle(40);
    chk(safety_output_pair, 2'b00);
    sw.press(MAXC + 100);
    idle(40);
    chk(safety_output_pair, 2'b00);
    sw.press(GOOD);
    wsop(2'b11);
    wr(`LCR_A_EMIT, 32'h1);
    sw.press(GOOD);
    idle(40);
    chk({emit_lamp[0], emit_digit}, 5'h09);
    sw.hold(1'b1);
    rst_n <= 1'b0;
    idle(20);
    rst_n <= 1'b1;
    wr(`LCR_A_CTRL, 32'h1);
    idle(80);
    sw.hold(1'b0);
    idle(100);
    chk({emit_lamp, safety_output_pair}, 4'h4);
    sw.press(GOOD);
    wsop(2'b11);
    end_of_test();
  end
endmodule
